// >>> core/sfp_top.sv
// system configuration, status and flash protection register bank
//
// Overview of operation
// R1 - read/write configuration byte at FFF910
// R2 - read-only status byte at FFF914
// R3 - configuration kept through all power modes
// R4 - software writes configuration in active mode
// R5 - bit 0 enables io zone bus
// R6 - bit 1 drives pll clock pin
// R7 - bit 2 drives main clock pin
// R8 - bit 3 drives slow clock pin
// R9 - bit 4 low forces usb transceiver down
// R10 - bit 5 slows misc output slew
// R11 - bit 6 slows memory output slew
// R12 - status 2:0 hold environment pins from reset
// R13 - status 3 mirrors program flash busy
// R14 - software waits while any flash busy
// R15 - status 4 mirrors data flash busy
// R16 - software polls pipeline full when data busy
// R17 - boot area always refuses cpu writes
// R18 - writes need section enable, no global lock
// R19 - 8k program and 512 byte data sections
// R20 - section enables cleared at reset
// R21 - software clears enables after programming
// R22 - write lock on two of three clear
// R23 - read lock blocks external reads only
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_top (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // register port
   input wire sfp_pkg::sfp_addr_t i_reg_addr,
   input wire sfp_pkg::sfp_data_t i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output sfp_pkg::sfp_data_t o_reg_rdata,
   // environment pins, three signals each
   input wire logic [2:0] i_env_pin_in,
   output logic [2:0] o_env_pin_out,
   output logic [2:0] o_env_pin_oe_n,
   // clocks forwarded onto the pins
   input wire logic i_pll_clk,
   input wire logic i_main_clk,
   input wire logic i_slow_clk,
   // pad and system controls
   output logic o_io_zone_bus_on,
   output logic o_usb_xcvr_lowpower,
   output logic o_misc_io_slow,
   output logic o_mem_io_slow,
   input wire logic i_usb_ctrl_active,
   input wire logic i_func_word_usb_en,
   // flash busy flags
   input wire logic i_prog_flash_busy,
   input wire logic i_data_flash_busy,
   // protection word fields
   input wire sfp_pkg::sfp_vote_t i_write_lock_bits,
   input wire sfp_pkg::sfp_vote_t i_read_lock_bits,
   input wire sfp_pkg::sfp_addr_t i_boot_region_end,
   // cpu flash write check
   input wire logic i_cpu_flash_wr,
   input wire sfp_pkg::sfp_addr_t i_cpu_flash_addr,
   output logic o_flash_wr_grant,
   output logic o_flash_wr_reject,
   // external debugger or programmer read gate, and the global write lock level
   output logic o_global_read_lock,
   output logic o_global_write_lock
);
   import sfp_pkg::*;

   // stored state
   // straps and protection fields reload on every reset edge
   logic [7:0] clock_output_config;
   logic [2:0] sampled_env_pins;
   logic [15:0] prog_sections_we_low;
   logic [15:0] prog_sections_we_high;
   logic [15:0] data_sections_we;
   logic write_reject_seen;
   sfp_addr_t boot_region_end;
   logic global_write_lock;
   logic global_read_lock;
   logic [2:0] env_sync;
   logic wr_allow;

   // decoded access
   sfp_sel_e sel;
   wire wr_cfg;
   wire wr_pwe_lo;
   wire wr_pwe_hi;
   wire wr_dwe;
   wire wr_wrej;
   wire [7:0] device_status;
   wire any_flash_busy;
   wire data_flash_busy;
   wire [7:0] next_cfg;
   wire next_reject_seen;
   wire sfp_addr_t boot_clamped;
   sfp_data_t next_rdata;
   wire next_grant;
   wire next_reject;
   wire reject_clear;
   wire usb_wanted;
   wire cfg_io_zone;
   wire cfg_pll_drive;
   wire cfg_main_drive;
   wire cfg_slow_drive;
   wire cfg_usb_allow;
   wire cfg_misc_slow;
   wire cfg_mem_slow;

   // environment pins come from outside the clock domain
   // the synchroniser is never reset, so straps keep flowing while reset
   // is held and the last reset edge sees settled pin levels
   sfp_sync #(
      .WIDTH(3)
   ) u_env_sync (
      .i_mclk(i_mclk),
      .i_sys_rst(1'h0),
      .i_async(i_env_pin_in),
      .o_sync(env_sync)
   );

   // flash write permission
   // the guard is plain logic, its verdict is registered further down
   sfp_write_guard u_guard (
      .i_addr(i_cpu_flash_addr),
      .i_boot_end(boot_region_end),
      .i_prog_we_low(prog_sections_we_low),
      .i_prog_we_high(prog_sections_we_high),
      .i_data_we(data_sections_we),
      .i_write_locked(global_write_lock),
      .o_allow(wr_allow)
   );

   // address decode
   // unmapped addresses select nothing: writes vanish, reads give zero
   always_comb begin
      case (i_reg_addr)
         `SFP_ADDR_CFG: begin
            sel = SFP_SEL_CFG;
         end
         `SFP_ADDR_STAT: begin
            sel = SFP_SEL_STAT;
         end
         `SFP_ADDR_PWE_LO: begin
            sel = SFP_SEL_PWE_LO;
         end
         `SFP_ADDR_PWE_HI: begin
            sel = SFP_SEL_PWE_HI;
         end
         `SFP_ADDR_DWE: begin
            sel = SFP_SEL_DWE;
         end
         `SFP_ADDR_WREJ: begin
            sel = SFP_SEL_WREJ;
         end
         default: begin
            sel = SFP_SEL_NONE;
         end
      endcase
   end

   // R2 the status address has no write strobe at all
   // R1 writable config
   assign wr_cfg = i_reg_wr && (sel == SFP_SEL_CFG);
   assign wr_pwe_lo = i_reg_wr && (sel == SFP_SEL_PWE_LO);
   assign wr_pwe_hi = i_reg_wr && (sel == SFP_SEL_PWE_HI);
   assign wr_dwe = i_reg_wr && (sel == SFP_SEL_DWE);
   assign wr_wrej = i_reg_wr && (sel == SFP_SEL_WREJ);
   // reserved top bit never stores
   assign next_cfg = i_reg_wdata[7:0] & `SFP_CFG_WMASK;

   // configuration fields by name
   assign cfg_io_zone = clock_output_config[`SFP_CFG_IOZONE];
   assign cfg_pll_drive = clock_output_config[`SFP_CFG_PLLOE];
   assign cfg_main_drive = clock_output_config[`SFP_CFG_MAINOE];
   assign cfg_slow_drive = clock_output_config[`SFP_CFG_SLOWOE];
   assign cfg_usb_allow = clock_output_config[`SFP_CFG_USBEN];
   assign cfg_misc_slow = clock_output_config[`SFP_CFG_MISCSLW];
   assign cfg_mem_slow = clock_output_config[`SFP_CFG_MEMSLW];

   // R3 config register, no power mode input touches it
   // keeping writes out of low-power modes is left to software
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         clock_output_config <= `SFP_CFG_RESET;
      end else if (wr_cfg) begin
         clock_output_config <= next_cfg;
      end
   end

   // R20 section write enables, cleared by reset
   // a section takes cpu writes only after software sets its bit
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         prog_sections_we_low <= `SFP_WE_RESET;
      end else if (wr_pwe_lo) begin
         prog_sections_we_low <= i_reg_wdata;
      end
   end

   // R20 upper program block enables
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         prog_sections_we_high <= `SFP_WE_RESET;
      end else if (wr_pwe_hi) begin
         prog_sections_we_high <= i_reg_wdata;
      end
   end

   // R20 data flash enables
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         data_sections_we <= `SFP_WE_RESET;
      end else if (wr_dwe) begin
         data_sections_we <= i_reg_wdata;
      end
   end

   // R12 environment pins caught while reset is held
   // every reset edge captures, the last one before release stays
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sampled_env_pins <= env_sync;
      end
   end

   // R17 boot end clamped to the largest allowed area
   // a larger end would pull part of the code area into the boot area
   assign boot_clamped = (i_boot_region_end > `SFP_BOOT_LIMIT) ?
      `SFP_BOOT_LIMIT : i_boot_region_end;

   // R22 R23 protection word fields take effect at reset only
   // a rewritten protection word only counts after the next reset
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         boot_region_end <= boot_clamped;
         global_write_lock <= sfp_lock_vote(i_write_lock_bits);
         global_read_lock <= sfp_lock_vote(i_read_lock_bits);
      end
   end

   // R13 R15 busy mirrors
   // the flash interfaces share this clock, so no synchroniser is needed
   assign any_flash_busy = i_prog_flash_busy;
   assign data_flash_busy = i_data_flash_busy;

   // R2 status assembled from live state, no write path
   assign device_status = {3'h0, data_flash_busy, any_flash_busy,
      sampled_env_pins};

   // R17 R18 flash write verdict, one cycle after the request
   assign next_grant = i_cpu_flash_wr && wr_allow;
   assign next_reject = i_cpu_flash_wr && !wr_allow;
   // exactly one pulse per request, none while idle
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_flash_wr_grant <= 1'h0;
         o_flash_wr_reject <= 1'h0;
      end else begin
         o_flash_wr_grant <= next_grant;
         o_flash_wr_reject <= next_reject;
      end
   end

   // software clears the record by writing one to its bit
   assign reject_clear = wr_wrej && i_reg_wdata[`SFP_WREJ_CLEAR];
   // sticky record of a refused write, a new refusal beats the clear
   assign next_reject_seen = (o_flash_wr_reject) ? 1'h1 :
      (reject_clear) ? 1'h0 : write_reject_seen;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         write_reject_seen <= 1'h0;
      end else begin
         write_reject_seen <= next_reject_seen;
      end
   end

   // read data selection
   always_comb begin
      case (sel)
         SFP_SEL_CFG: begin
            next_rdata = {8'h00, clock_output_config};
         end
         SFP_SEL_STAT: begin
            next_rdata = {8'h00, device_status};
         end
         SFP_SEL_PWE_LO: begin
            next_rdata = prog_sections_we_low;
         end
         SFP_SEL_PWE_HI: begin
            next_rdata = prog_sections_we_high;
         end
         SFP_SEL_DWE: begin
            next_rdata = data_sections_we;
         end
         SFP_SEL_WREJ: begin
            next_rdata = {15'h0000, write_reject_seen};
         end
         default: begin
            next_rdata = 16'h0000;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   // zero outside the answer cycle, so read sources can be or-ed
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end else begin
         o_reg_rdata <= 16'h0000;
      end
   end

   // R6 R7 R8 clock forwarding onto the environment pins
   // clocks pass straight through, the enables alone decide what shows
   assign o_env_pin_out[0] = i_pll_clk;
   assign o_env_pin_out[1] = i_main_clk;
   assign o_env_pin_out[2] = i_slow_clk;
   // enables are low while driving, pins float otherwise
   assign o_env_pin_oe_n[0] = ~cfg_pll_drive;
   assign o_env_pin_oe_n[1] = ~cfg_main_drive;
   assign o_env_pin_oe_n[2] = ~cfg_slow_drive;

   // R5 io zone external bus
   assign o_io_zone_bus_on = cfg_io_zone;
   // R9 transceiver wanted by controller and function word together
   assign usb_wanted = i_usb_ctrl_active && i_func_word_usb_en;
   // R9 a cleared enable bit forces low power whatever the rest says
   assign o_usb_xcvr_lowpower = !cfg_usb_allow || !usb_wanted;
   // R10 R11 slew selects
   assign o_misc_io_slow = cfg_misc_slow;
   assign o_mem_io_slow = cfg_mem_slow;

   // R23 read lock gates external reads only, cpu reads untouched
   assign o_global_read_lock = global_read_lock;
   // write lock level goes out to the flash controller too
   assign o_global_write_lock = global_write_lock;
endmodule : sfp_top
`default_nettype wire

// >>> core/sfp_consts.svh
// constants for the system configuration and flash protection block
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// register byte addresses
`define SFP_ADDR_CFG 24'hFFF910
`define SFP_ADDR_STAT 24'hFFF914
`define SFP_ADDR_PWE_LO 24'hFFF920
`define SFP_ADDR_PWE_HI 24'hFFF924
`define SFP_ADDR_DWE 24'hFFF928
`define SFP_ADDR_WREJ 24'hFFF92C

// clock_output_config fields and reset value
`define SFP_CFG_IOZONE 0
`define SFP_CFG_PLLOE 1
`define SFP_CFG_MAINOE 2
`define SFP_CFG_SLOWOE 3
`define SFP_CFG_USBEN 4
`define SFP_CFG_MISCSLW 5
`define SFP_CFG_MEMSLW 6
`define SFP_CFG_RESET 8'h10
`define SFP_CFG_WMASK 8'h7F

// device_status fields
`define SFP_STAT_ANYBUSY 3
`define SFP_STAT_DATABUSY 4

// section enable reset value and reject record clear bit
`define SFP_WE_RESET 16'h0000
`define SFP_WREJ_CLEAR 0

// flash areas
`define SFP_BOOT_LIMIT 24'h001C00
`define SFP_PROG_TOP 24'h03FFFF
`define SFP_DATA_BASE 24'h0E0000
`define SFP_DATA_TOP 24'h0E1FFF
`define SFP_PROG_SEC_LSB 13
`define SFP_DATA_SEC_LSB 9
`define SFP_BLOCK_SEL_BIT 17

`endif

// >>> core/sfp_pkg.sv
// types and shared functions of the configuration and protection block
package sfp_pkg;
   typedef logic [23:0] sfp_addr_t;
   typedef logic [15:0] sfp_data_t;
   typedef logic [2:0] sfp_vote_t;
   // which register a bus address selects
   typedef enum logic [2:0] {
      SFP_SEL_NONE, SFP_SEL_CFG, SFP_SEL_STAT, SFP_SEL_PWE_LO,
      SFP_SEL_PWE_HI, SFP_SEL_DWE, SFP_SEL_WREJ
   } sfp_sel_e;

   // lock is on when at least two of three stored bits are clear
   function automatic logic sfp_lock_vote(input sfp_vote_t bits);
      sfp_lock_vote = (~bits[0] & ~bits[1]) | (~bits[0] & ~bits[2]) |
         (~bits[1] & ~bits[2]);
   endfunction : sfp_lock_vote
endpackage : sfp_pkg

// >>> core/sfp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
   parameter int WIDTH = 3
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         stage1 <= '0;
         o_sync <= '0;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule : sfp_sync
`default_nettype wire

// >>> core/sfp_write_guard.sv
// decides whether a cpu write to flash may proceed
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_write_guard (
   input wire sfp_pkg::sfp_addr_t i_addr,
   input wire sfp_pkg::sfp_addr_t i_boot_end,
   input wire logic [15:0] i_prog_we_low,
   input wire logic [15:0] i_prog_we_high,
   input wire logic [15:0] i_data_we,
   input wire logic i_write_locked,
   output logic o_allow
);
   import sfp_pkg::*;
   wire in_boot;
   wire in_code;
   wire in_data;
   wire [3:0] prog_idx;
   wire [3:0] data_idx;
   wire prog_bit;
   wire data_bit;

   // R17 boot area
   assign in_boot = (i_addr < i_boot_end);
   assign in_code = !in_boot && (i_addr <= `SFP_PROG_TOP);
   assign in_data = (i_addr >= `SFP_DATA_BASE) && (i_addr <= `SFP_DATA_TOP);
   // R19 section index
   assign prog_idx = i_addr[`SFP_PROG_SEC_LSB +: 4];
   assign data_idx = i_addr[`SFP_DATA_SEC_LSB +: 4];
   assign prog_bit = i_addr[`SFP_BLOCK_SEL_BIT] ? i_prog_we_high[prog_idx]
      : i_prog_we_low[prog_idx];
   assign data_bit = i_data_we[data_idx];
   // R18 R22 section enable and global lock
   assign o_allow = !i_write_locked &&
      ((in_code && prog_bit) || (in_data && data_bit));
endmodule : sfp_write_guard
`default_nettype wire

// >>> bench/sfp_top_chk.sv
// port checker for the configuration and protection block
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_chk (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire sfp_pkg::sfp_addr_t i_reg_addr,
   input wire sfp_pkg::sfp_data_t i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire sfp_pkg::sfp_data_t o_reg_rdata,
   input wire logic [2:0] o_env_pin_oe_n,
   input wire logic o_io_zone_bus_on,
   input wire logic o_usb_xcvr_lowpower,
   input wire logic o_misc_io_slow,
   input wire logic o_mem_io_slow,
   input wire sfp_pkg::sfp_vote_t i_write_lock_bits,
   input wire sfp_pkg::sfp_vote_t i_read_lock_bits,
   input wire sfp_pkg::sfp_addr_t i_boot_region_end,
   input wire logic i_cpu_flash_wr,
   input wire sfp_pkg::sfp_addr_t i_cpu_flash_addr,
   input wire logic o_flash_wr_grant,
   input wire logic o_flash_wr_reject,
   input wire logic o_global_read_lock,
   input wire logic o_global_write_lock
);
   import sfp_pkg::*;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   // a bus write to the configuration byte
   wire cfg_wr = i_reg_wr && (i_reg_addr == `SFP_ADDR_CFG);
   property p_pins;
      cfg_wr |=> o_env_pin_oe_n == ~$past(i_reg_wdata[3:1]);
   endproperty
   a_pins: assert property (p_pins) else $error("pin enables");
   property p_ioslew;
      cfg_wr |=> {o_mem_io_slow, o_misc_io_slow, o_io_zone_bus_on} ==
         $past({i_reg_wdata[6:5], i_reg_wdata[0]});
   endproperty
   a_ioslew: assert property (p_ioslew) else $error("bus or slew");
   property p_usb;
      cfg_wr && !i_reg_wdata[4] |=> o_usb_xcvr_lowpower;
   endproperty
   a_usb: assert property (p_usb) else $error("usb not forced low");
   property p_boot;
      i_cpu_flash_wr && i_cpu_flash_addr < i_boot_region_end &&
         i_cpu_flash_addr < `SFP_BOOT_LIMIT |=> o_flash_wr_reject;
   endproperty
   a_boot: assert property (p_boot) else $error("boot write let in");
   property p_wlock;
      i_cpu_flash_wr && o_global_write_lock |=> o_flash_wr_reject;
   endproperty
   a_wlock: assert property (p_wlock) else $error("locked write");
   property p_grant;
      o_flash_wr_grant |-> $past(i_cpu_flash_wr) && !o_flash_wr_reject &&
         !o_global_write_lock;
   endproperty
   a_grant: assert property (p_grant) else $error("stray grant");
   property p_wvote;
      $fell(i_sys_rst) |->
         o_global_write_lock == ($countones($past(i_write_lock_bits)) < 2);
   endproperty
   a_wvote: assert property (p_wvote) else $error("write vote");
   property p_rvote;
      $fell(i_sys_rst) |->
         o_global_read_lock == ($countones($past(i_read_lock_bits)) < 2);
   endproperty
   a_rvote: assert property (p_rvote) else $error("read vote");
   property p_rdidle;
      !i_reg_rd |=> o_reg_rdata == 16'h0000;
   endproperty
   a_rdidle: assert property (p_rdidle) else $error("stray rdata");
endmodule : sfp_chk
bind sfp_top sfp_chk u_chk (.i_mclk, .i_sys_rst, .i_reg_addr,
   .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_env_pin_oe_n,
   .o_io_zone_bus_on, .o_usb_xcvr_lowpower, .o_misc_io_slow, .o_mem_io_slow,
   .i_write_lock_bits, .i_read_lock_bits, .i_boot_region_end,
   .i_cpu_flash_wr, .i_cpu_flash_addr, .o_flash_wr_grant,
   .o_flash_wr_reject, .o_global_read_lock, .o_global_write_lock);
`default_nettype wire

// >>> bench/sfp_far_model.sv
// model of the strap pins and the flash busy flags
`timescale 1ns/1ps
`default_nettype none
module sfp_far_model (
   input wire logic i_sys_rst,
   input wire logic [2:0] i_env_val,
   input wire logic [1:0] i_busy_req,
   output logic [2:0] o_env_pin,
   output logic o_prog_busy,
   output logic o_data_busy
);
   // straps during reset
   // straps shown only in reset, pins move away afterwards
   assign o_env_pin = i_sys_rst ? i_env_val : ~i_env_val;
   // busy flag copies
   // program interface flag is up while either memory is busy
   assign o_prog_busy = |i_busy_req;
   assign o_data_busy = i_busy_req[1];
endmodule : sfp_far_model
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the configuration and protection block
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module testbench;
   import sfp_pkg::*;
   logic i_mclk, i_sys_rst = 1'h1, wr = 1'h0, rd = 1'h0, fwr = 1'h0;
   logic usb_act = 1'h1, fword = 1'h1, pbusy, dbusy, io_on, lowp;
   logic mslow, memslow, grant, rej, rlock, wlock;
   logic [1:0] busy = 2'h0;
   logic [2:0] env, oe_n, pout, wbits = 3'h7, rbits = 3'h7;
   sfp_addr_t addr = 24'h0, faddr = 24'h0, bend = 24'h001000;
   sfp_data_t wdata = 16'h0, rdata;
   int fail_count = 0, checks = 0, cyc = 0;
   // far side and design
   sfp_far_model far (.i_sys_rst, .i_env_val(3'h5), .i_busy_req(busy),
      .o_env_pin(env), .o_prog_busy(pbusy), .o_data_busy(dbusy));
   sfp_top dut (.i_mclk, .i_sys_rst, .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_env_pin_in(env), .o_env_pin_out(pout), .o_env_pin_oe_n(oe_n),
      .i_pll_clk(i_mclk), .i_main_clk(~i_mclk), .i_slow_clk(1'h1),
      .o_io_zone_bus_on(io_on), .o_usb_xcvr_lowpower(lowp),
      .o_misc_io_slow(mslow), .o_mem_io_slow(memslow),
      .i_usb_ctrl_active(usb_act), .i_func_word_usb_en(fword),
      .i_prog_flash_busy(pbusy), .i_data_flash_busy(dbusy),
      .i_write_lock_bits(wbits), .i_read_lock_bits(rbits),
      .i_boot_region_end(bend), .i_cpu_flash_wr(fwr),
      .i_cpu_flash_addr(faddr), .o_flash_wr_grant(grant),
      .o_flash_wr_reject(rej), .o_global_read_lock(rlock),
      .o_global_write_lock(wlock));
   // clock and hang guard
   initial begin
      i_mclk = 1'h0;
      forever #25 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input sfp_data_t got, input sfp_data_t exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset(input sfp_vote_t w, input sfp_vote_t r);
      @(posedge i_mclk);
      i_sys_rst <= 1'h1;
      wbits <= w;
      rbits <= r;
      repeat (20) @(posedge i_mclk);
      i_sys_rst <= 1'h0;
      #1;
   endtask : do_reset
   task automatic wreg(input sfp_addr_t a, input sfp_data_t d);
      @(posedge i_mclk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge i_mclk);
      wr <= 1'h0;
      #1;
   endtask : wreg
   task automatic rreg(input sfp_addr_t a, input sfp_data_t e);
      @(posedge i_mclk);
      rd <= 1'h1;
      addr <= a;
      @(posedge i_mclk);
      rd <= 1'h0;
      #1 chk(rdata, e);
   endtask : rreg
   task automatic fw(input sfp_addr_t a, input logic g);
      @(posedge i_mclk);
      fwr <= 1'h1;
      faddr <= a;
      @(posedge i_mclk);
      fwr <= 1'h0;
      #1 chk(16'({grant, rej}), 16'({g, ~g}));
   endtask : fw
   task automatic t_reset_vals;
      chk(16'(oe_n), 16'h0007);
      chk(16'(pout), 16'h0005);
      rreg(`SFP_ADDR_CFG, 16'h0010);
      rreg(`SFP_ADDR_STAT, 16'h0005);
      rreg(`SFP_ADDR_DWE, 16'h0000);
      rreg(24'hFFF918, 16'h0000);
   endtask : t_reset_vals
   task automatic t_cfg;
      logic [7:0] wv[4] = '{8'hFF, 8'h55, 8'hAA, 8'h00};
      logic [7:0] ov[4] = '{8'h31, 8'h2B, 8'h54, 8'h4E};
      foreach (wv[i]) begin
         wreg(`SFP_ADDR_CFG, 16'(wv[i]));
         chk(16'({lowp, memslow, mslow, oe_n, io_on}), 16'(ov[i]));
         rreg(`SFP_ADDR_CFG, 16'(wv[i] & 8'h7F));
      end
      wreg(`SFP_ADDR_CFG, 16'h0010);
      @(posedge i_mclk);
      fword <= 1'h0;
      #1 chk(16'(lowp), 16'h0001);
      @(posedge i_mclk);
      usb_act <= 1'h0;
      fword <= 1'h1;
      #1 chk(16'(lowp), 16'h0001);
      @(posedge i_mclk);
      usb_act <= 1'h1;
      #1 chk(16'(lowp), 16'h0000);
      wreg(`SFP_ADDR_STAT, 16'h00FF);
      rreg(`SFP_ADDR_STAT, 16'h0005);
   endtask : t_cfg
   task automatic t_busy;
      for (int b = 0; b < 4; b++) begin
         @(posedge i_mclk);
         busy <= b[1:0];
         rreg(`SFP_ADDR_STAT, {11'h0, b[1], |b[1:0], 3'h5});
      end
      @(posedge i_mclk);
      busy <= 2'h0;
   endtask : t_busy
   task automatic t_flash;
      rreg(`SFP_ADDR_STAT, 16'h0005);
      wreg(`SFP_ADDR_PWE_LO, 16'h0005);
      wreg(`SFP_ADDR_PWE_HI, 16'h0004);
      wreg(`SFP_ADDR_DWE, 16'h0004);
      fw(24'h000FFF, 1'h0);
      fw(24'h001000, 1'h1);
      fw(24'h005FFF, 1'h1);
      fw(24'h006000, 1'h0);
      fw(24'h024000, 1'h1);
      fw(24'h0E0400, 1'h1);
      fw(24'h0E0600, 1'h0);
      fw(24'h040000, 1'h0);
      rreg(`SFP_ADDR_WREJ, 16'h0001);
      wreg(`SFP_ADDR_WREJ, 16'h0001);
      rreg(`SFP_ADDR_WREJ, 16'h0000);
      rreg(`SFP_ADDR_PWE_HI, 16'h0004);
      wreg(`SFP_ADDR_PWE_LO, 16'h0000);
      fw(24'h001000, 1'h0);
   endtask : t_flash
   task automatic t_locks;
      do_reset(3'h1, 3'h6);
      chk(16'({wlock, rlock}), 16'h0002);
      wreg(`SFP_ADDR_PWE_LO, 16'h0004);
      fw(24'h004000, 1'h0);
      @(posedge i_mclk);
      bend <= 24'h00FFFF;
      do_reset(3'h3, 3'h4);
      chk(16'({wlock, rlock}), 16'h0001);
      rreg(`SFP_ADDR_CFG, 16'h0010);
      wreg(`SFP_ADDR_PWE_LO, 16'h0005);
      fw(24'h001BFF, 1'h0);
      fw(24'h001C00, 1'h1);
      fw(24'h004000, 1'h1);
   endtask : t_locks
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      do_reset(3'h7, 3'h7);
      t_reset_vals();
      t_cfg();
      t_busy();
      t_flash();
      t_locks();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
